// ==== common/rwu_pkg.sv ====
// constants, bus carrier and state encoding of the reset and watchdog unit
// assumes a 10 MHz bus clock that is also the machine cycle clock
package rwu_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	// register map
	localparam logic [15:0] OFF_FIXED_CLEAR = 16'h3ff0;
	localparam logic [15:0] OFF_SERVICE_KEY = 16'h001d;
	localparam logic [15:0] OFF_CONTROL = 16'h001e;
	// watchdog control fields
	localparam int BIT_FLAG = 4;
	localparam int BIT_CLKMON_EN = 3;
	localparam int BIT_WD_EN = 2;
	localparam int BIT_SEL_HI = 1;
	localparam int BIT_SEL_LO = 0;
	localparam int BIT_FIXED_CLEAR = 0;
	// service key values
	localparam logic [7:0] KEY_ARM = 8'h55;
	localparam logic [7:0] KEY_FIRE = 8'haa;
	localparam logic [7:0] READ_NONE = 8'h00;
	// timing
	localparam int CLK_NS = 100;
	localparam int MCYC_NS = 100;
	localparam int POR_CYCLES = 4064;
	localparam int PIN_LOW_TENTH_MCYC = 15;
	localparam int PIN_LOW_CYC = (PIN_LOW_TENTH_MCYC * MCYC_NS + 10 * CLK_NS - 1) / (10 * CLK_NS);
	localparam int CM_DRIVE_CYC = 4;
	localparam int WD_DRIVE_CYC = 4;
	// pin synchroniser reset value: {pin, slow, absent, mask, fixed option}
	localparam logic [4:0] SYNC_RST = 5'h10;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rwu_bus_req_t;
	typedef enum logic [1:0] {
		ST_POR = 2'b00,
		ST_HOLD = 2'b01,
		ST_RUN = 2'b11,
		ST_DRIVE = 2'b10
	} rwu_state_t;
endpackage

// ==== hdl/rwu_reset_watchdog.sv ====
// reset sequencer with a configurable and a fixed watchdog and clock monitor hooks
// assumes one 10 MHz clock, a register port on that clock and analog monitor flags on pins
// What this block does
// - reset comes from power-on, reset pin low, watchdog timeout or clock monitor trip.
// - any reset stops the core at once and reloads its start vector afterwards.
// - after power-on, wait 4064 clock cycles for the oscillator before going on.
// - software-controlled configuration drives the reset pin low during that power-on wait.
// - if the pin is still low after the wait, stay in reset until released.
// - reset pin is input only in mask mode once the strap is synchronised after power-on, bidirectional otherwise.
// - reset pin held low for one and a half machine cycles resets the device.
// - software-controlled mode drives the pin low on watchdog, clock monitor or power-on reset.
// - configurable watchdog starts by software enable outside mask mode; fixed one by a preset option in mask mode.
// - configurable watchdog is serviced by writing 55 then AA to its key register.
// - a watchdog expiry gives a full system reset, as power-on or pin would.
// - key register is write only; reading it returns nothing useful.
// - flag is set by watchdog or clock monitor reset, cleared by reading control.
// - clock monitor enable is always readable and takes only one write.
// - enable and timeout select clear on reset and take one combined write.
// - the top three control bits read as zero.
// - configurable timeout is two to the fifteen cycles times 1, 4, 16 or 64.
// - fixed watchdog is an 18-bit counter on the bus clock.
// - writing zero to bit 0 at 3ff0 clears the fixed watchdog counter.
// - reading 3ff0 returns the port B interrupt option contents.
// - both watchdogs keep counting in wait mode.
// - clock monitor trip drives the pin four cycles, or while the clock is absent.
// - watchdog counters clear when stop mode is entered.
`timescale 1ns/1ps

module rwu_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstN,
	// raw and agreed levels
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1Q;
	logic [W-1:0] s2Q;
	logic [W-1:0] s3Q;

	// three stages; a bit moves only once stages two and three agree
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			s1Q <= RST;
			s2Q <= RST;
			s3Q <= RST;
			dout <= RST;
		end
		else
		begin
			s1Q <= din;
			s2Q <= s1Q;
			s3Q <= s2Q;
			dout <= (s2Q & s3Q) | (~(s2Q ^ s3Q) & s2Q) | ((s2Q ^ s3Q) & dout);
		end
	end
endmodule // rwu_sync3

module rwu_reset_watchdog
	import rwu_pkg::*;
#(
	parameter int WD_PRESCALE_LOG2 = 15,
	parameter int FIXED_WD_BITS = 18
) (
	// clock and power-on reset
	input wire logic clk,
	input wire logic arst_n,
	// register port
	input wire rwu_bus_req_t busReq,
	output logic [7:0] busRdata,
	// board reset pin
	input wire logic resetPinIn,
	output logic resetPinOut,
	output logic resetPinOe_n,
	// clock monitor detector flags and option straps
	input wire logic clkSlowIn,
	input wire logic clkAbsentIn,
	input wire logic maskModeIn,
	input wire logic fixedWdOptIn,
	input wire logic [7:0] portBOptIn,
	// core side
	input wire logic stopEntry,
	output logic sysRst_n,
	output logic vectorLoad
);
	localparam int CW = WD_PRESCALE_LOG2 + 6;

	logic rstS1Q, rstN;
	logic [4:0] syncLvl;
	logic pinLvl, slowLvl, absentLvl, maskLvl, fixOptLvl;
	rwu_state_t stateQ, stateD;
	logic [11:0] porCntQ;
	logic [2:0] driveCntQ, holdCntQ;
	logic [1:0] pinLowCntQ;
	logic maskQ, fixOptQ, cmCauseQ, wdEnQ, cmeQ, cfgLockQ, cmeLockQ, flagQ, armedQ;
	logic [1:0] selQ;
	logic [CW-1:0] wdCntQ, wdLast;
	logic [FIXED_WD_BITS-1:0] fixCntQ;
	logic running, wrCtrl, rdCtrl, wrKey, wrFix, service, fixClear;
	logic wdTimeout, fixTimeout, cmTrip, pinReset, driveNow;

	// power-on reset release through two stages
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rstS1Q <= 1'b0;
			rstN <= 1'b0;
		end
		else
		begin
			rstS1Q <= 1'b1;
			rstN <= rstS1Q;
		end
	end

	rwu_sync3 #(
		.W(5),
		.RST(SYNC_RST)
	) uSync (
		.clk(clk),
		.rstN(rstN),
		.din({resetPinIn, clkSlowIn, clkAbsentIn, maskModeIn, fixedWdOptIn}),
		.dout(syncLvl)
	);

	assign {pinLvl, slowLvl, absentLvl, maskLvl, fixOptLvl} = syncLvl;

	// bus decode
	assign wrCtrl = busReq.wr && (busReq.addr == OFF_CONTROL);
	assign rdCtrl = busReq.rd && (busReq.addr == OFF_CONTROL);
	assign wrKey = busReq.wr && (busReq.addr == OFF_SERVICE_KEY);
	assign wrFix = busReq.wr && (busReq.addr == OFF_FIXED_CLEAR);
	assign running = (stateQ == ST_RUN);
	assign service = wrKey && armedQ && (busReq.wdata == KEY_FIRE);
	assign fixClear = wrFix && !busReq.wdata[BIT_FIXED_CLEAR];

	// timeout end point grows by four per select step
	assign wdLast = CW'((64'd1 << (WD_PRESCALE_LOG2 + 2 * int'(selQ))) - 64'd1);
	assign wdTimeout = running && wdEnQ && !maskQ && (wdCntQ == wdLast);
	assign fixTimeout = running && maskQ && fixOptQ && (&fixCntQ);
	assign cmTrip = running && cmeQ && !maskQ && (slowLvl || absentLvl);
	assign pinReset = running && (pinLowCntQ == 2'(PIN_LOW_CYC));

	// reset sequencer
	always_comb
	begin
		stateD = stateQ;
		unique case (stateQ)
			ST_POR:
				if (porCntQ == 12'(POR_CYCLES - 1))
					stateD = ST_HOLD;
			ST_HOLD:
				if (pinLvl && (&holdCntQ))
					stateD = ST_RUN;
			ST_RUN:
				if (wdTimeout || fixTimeout || cmTrip)
					stateD = ST_DRIVE;
				else if (pinReset)
					stateD = ST_HOLD;
			ST_DRIVE:
				if (driveCntQ == 3'(CM_DRIVE_CYC - 1) && !(cmCauseQ && absentLvl))
					stateD = ST_HOLD;
		endcase
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			stateQ <= ST_POR;
		else
			stateQ <= stateD;
	end

	// stabilisation and drive counters
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			porCntQ <= 12'h000;
			driveCntQ <= 3'h0;
			holdCntQ <= 3'h0;
		end
		else
		begin
			if (stateQ == ST_POR)
				porCntQ <= porCntQ + 12'h001;
			if (stateQ != ST_DRIVE)
				driveCntQ <= 3'h0;
			else if (driveCntQ != 3'(WD_DRIVE_CYC - 1))
				driveCntQ <= driveCntQ + 3'h1;
			// eight cycles in hold outlast the pin filter lag after our own drive
			if (stateQ != ST_HOLD)
				holdCntQ <= 3'h0;
			else if (!(&holdCntQ))
				holdCntQ <= holdCntQ + 3'h1;
		end
	end

	// pin low must be seen for whole machine cycles after filtering
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			pinLowCntQ <= 2'h0;
		else if (pinLvl)
			pinLowCntQ <= 2'h0;
		else if (pinLowCntQ != 2'(PIN_LOW_CYC))
			pinLowCntQ <= pinLowCntQ + 2'h1;
	end

	// straps are caught while the oscillator settles, then frozen
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			maskQ <= 1'b0;
			fixOptQ <= 1'b0;
		end
		else if (stateQ == ST_POR)
		begin
			maskQ <= maskLvl;
			fixOptQ <= fixOptLvl;
		end
	end

	// remember whether the running reset came from the clock monitor
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			cmCauseQ <= 1'b0;
		else if (running)
			cmCauseQ <= cmTrip && !wdTimeout && !fixTimeout;
	end

	// control register; every system reset unlocks and clears it
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			wdEnQ <= 1'b0;
			selQ <= 2'h0;
			cmeQ <= 1'b0;
			cfgLockQ <= 1'b0;
			cmeLockQ <= 1'b0;
		end
		else if (!running)
		begin
			wdEnQ <= 1'b0;
			selQ <= 2'h0;
			cmeQ <= 1'b0;
			cfgLockQ <= 1'b0;
			cmeLockQ <= 1'b0;
		end
		else if (wrCtrl)
		begin
			if (!cfgLockQ)
			begin
				wdEnQ <= busReq.wdata[BIT_WD_EN];
				selQ <= {busReq.wdata[BIT_SEL_HI], busReq.wdata[BIT_SEL_LO]};
			end
			if (!cmeLockQ)
				cmeQ <= busReq.wdata[BIT_CLKMON_EN];
			cfgLockQ <= 1'b1;
			cmeLockQ <= 1'b1;
		end
	end

	// flag survives system resets; a new cause beats a clearing read
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			flagQ <= 1'b0;
		else if (wdTimeout || fixTimeout || cmTrip)
			flagQ <= 1'b1;
		else if (rdCtrl)
			flagQ <= 1'b0;
	end

	// key sequence: any other value in between disarms
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			armedQ <= 1'b0;
		else if (!running)
			armedQ <= 1'b0;
		else if (wrKey)
			armedQ <= (busReq.wdata == KEY_ARM);
	end

	// counters run regardless of wait mode, so wait gives no shelter
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			wdCntQ <= '0;
		else if (!running || !wdEnQ || maskQ || stopEntry || service)
			wdCntQ <= '0;
		else
			wdCntQ <= wdCntQ + CW'(1);
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			fixCntQ <= '0;
		else if (!running || !maskQ || !fixOptQ || stopEntry || fixClear)
			fixCntQ <= '0;
		else
			fixCntQ <= fixCntQ + FIXED_WD_BITS'(1);
	end

	// read data stands for one cycle only
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			busRdata <= 8'h00;
		else if (rdCtrl)
			busRdata <= {3'h0, flagQ, cmeQ, wdEnQ, selQ};
		else if (busReq.rd && busReq.addr == OFF_FIXED_CLEAR)
			busRdata <= portBOptIn;
		else
			busRdata <= READ_NONE;
	end

	// pin drive: in mask mode only in reset and the first power-on cycles, before the strap passes the synchroniser
	assign driveNow = (stateQ == ST_POR && !maskLvl) || (stateQ == ST_DRIVE && !maskQ);

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			resetPinOut <= 1'b0;
			resetPinOe_n <= 1'b0;
			sysRst_n <= 1'b0;
			vectorLoad <= 1'b0;
		end
		else
		begin
			resetPinOut <= 1'b0;
			resetPinOe_n <= !driveNow;
			sysRst_n <= (stateD == ST_RUN);
			vectorLoad <= (stateD == ST_RUN) && !running;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstN);

	sequence sArmed;
		wrKey && busReq.wdata == KEY_ARM && running;
	endsequence

	sequence sFire;
		wrKey && busReq.wdata == KEY_FIRE && armedQ && running;
	endsequence

	sequence sSlowTrip;
		cmTrip && !absentLvl && !wdTimeout && !maskQ;
	endsequence

	a_por_pin_drive: assert property (stateQ == ST_POR && !maskLvl |=> !resetPinOe_n)
		else $error("pin not driven during power-on wait");
	a_mask_input_only: assert property (maskQ && stateQ != ST_POR |=> resetPinOe_n)
		else $error("pin driven in mask mode");
	a_wd_sys_reset: assert property (wdTimeout |=> !sysRst_n ##1 !resetPinOe_n)
		else $error("watchdog timeout did not reset and drive pin");
	a_key_service: assert property (sArmed ##[2:20] sFire |=> wdCntQ == '0)
		else $error("key sequence did not clear watchdog");
	a_flag_set: assert property (wdTimeout || fixTimeout || cmTrip |=> flagQ)
		else $error("flag not set by watchdog or monitor reset");
	a_flag_clear: assert property (rdCtrl && !wdTimeout && !fixTimeout && !cmTrip |=> !flagQ)
		else $error("flag not cleared by control read");
	a_cfg_once: assert property (cfgLockQ && wrCtrl && running |=> $stable(wdEnQ) && $stable(selQ))
		else $error("locked watchdog setting changed");
	a_top_zero: assert property (busReq.rd |=> busRdata[7:5] == 3'h0 || $past(busReq.addr) != OFF_CONTROL)
		else $error("upper control bits not zero");
	a_key_read: assert property (busReq.rd && busReq.addr == OFF_SERVICE_KEY |=> busRdata == READ_NONE)
		else $error("key register returned data");
	a_pin_reset: assert property (pinReset && !wdTimeout && !fixTimeout && !cmTrip |=> stateQ == ST_HOLD)
		else $error("pin low did not reset");
	a_stop_clear: assert property (stopEntry |=> wdCntQ == '0 && fixCntQ == '0)
		else $error("stop entry did not clear counters");
	a_wd_disabled: assert property (!wdEnQ |=> wdCntQ == '0)
		else $error("disabled watchdog counted");
	a_cm_slow_drive: assert property (sSlowTrip |=> ##1 (!resetPinOe_n)[*4] ##1 resetPinOe_n)
		else $error("slow clock drive not four cycles");
	a_fixed_read: assert property (busReq.rd && busReq.addr == OFF_FIXED_CLEAR |=> busRdata == $past(portBOptIn))
		else $error("fixed clear read not option contents");
endmodule // rwu_reset_watchdog

// ==== verif/rwu_board_pin.sv ====
// board side of the reset pin: pull-up, device drive and an external holder
// assumes the device drives low with its enable low and the bench plays the holder
`timescale 1ns/1ps

module rwu_board_pin (
	// device drive
	input wire logic pinOut,
	input wire logic pinOe_n,
	// external holder, may keep the pin low as long as it likes
	input wire logic holdLow,
	// wire level seen by the device
	output logic pinLevel
);
	// pull-up wins only when nobody pulls low
	assign pinLevel = holdLow ? 1'b0 : (!pinOe_n ? pinOut : 1'b1);
endmodule // rwu_board_pin

// ==== verif/tb_rwu_reset_watchdog.sv ====
// self-checking bench for the reset and watchdog unit with short watchdog counts
// assumes the board pin model beside it and a 10 MHz clock
`timescale 1ns/1ps

module tb_rwu_reset_watchdog
	import rwu_pkg::*;
;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	rwu_bus_req_t busReq = '0;
	logic [7:0] busRdata, r;
	logic [7:0] portBOpt = 8'h00;
	logic pinLevel, pinOut, pinOe_n, sysRst_n, vectorLoad;
	logic holdLow = 1'b0, clkSlow = 1'b0, maskMode = 1'b0, fixedOpt = 1'b0, stopEntry = 1'b0;
	logic clkAbsent = 1'b0;
	logic [15:0] lfsr = 16'h6840;
	int bad_count = 0, tests_run = 0, cyc = 0, n, i;
	localparam int CEIL = 20000;

	// 100 ns clock
	always #50 clk = ~clk;

	// short prescaler and fixed counter keep the fixed timeout and the two shortest configurable timeouts under a hundred cycles
	rwu_reset_watchdog #(.WD_PRESCALE_LOG2(4), .FIXED_WD_BITS(6)) dut (
		.clk(clk), .arst_n(arst_n), .busReq(busReq), .busRdata(busRdata),
		.resetPinIn(pinLevel), .resetPinOut(pinOut), .resetPinOe_n(pinOe_n),
		.clkSlowIn(clkSlow), .clkAbsentIn(clkAbsent), .maskModeIn(maskMode),
		.fixedWdOptIn(fixedOpt), .portBOptIn(portBOpt), .stopEntry(stopEntry),
		.sysRst_n(sysRst_n), .vectorLoad(vectorLoad));

	rwu_board_pin board (.pinOut(pinOut), .pinOe_n(pinOe_n), .holdLow(holdLow),
		.pinLevel(pinLevel));

	function automatic logic [7:0] ctl(logic f, logic c, logic e, logic [1:0] s);
		return {3'b000, f, c, e, s};
	endfunction

	function automatic int wdc(logic [1:0] s);
		return 1 << (4 + 2 * s);
	endfunction

	task automatic rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		r = lfsr[7:0];
	endtask

	task automatic chk(logic [7:0] seen, logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// hang guard: a run past the ceiling is a mismatch
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == CEIL)
		begin
			bad_count++;
			give_verdict();
		end
	end

	// one-cycle strobes, one idle cycle between transfers
	task automatic wr(logic [15:0] a, logic [7:0] d);
		@(posedge clk);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		busReq <= '0;
	endtask

	task automatic rchk(logic [15:0] a, logic [7:0] e);
		@(posedge clk);
		busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		busReq <= '0;
		@(negedge clk);
		chk(busRdata, e);
	endtask

	// cycles counted in n until the core reset falls
	task automatic wait_rst(int lim);
		while (sysRst_n !== 1'b0 && n < lim)
		begin
			@(negedge clk);
			n++;
		end
	endtask

	// wait for the core to run, start vector pulse in its first cycle
	task automatic wait_run(int lim);
		n = 0;
		while (sysRst_n !== 1'b1 && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		chk(sysRst_n, 1'b1);
		chk(vectorLoad, 1'b1);
	endtask

	// length of the device's own low drive on the pin
	task automatic drive_len();
		n = 0;
		repeat (3) if (pinOe_n !== 1'b0) @(negedge clk);
		while (pinOe_n === 1'b0 && n < 100)
		begin
			n++;
			@(negedge clk);
		end
	endtask

	// main sequence
	initial
	begin
		rnd();
		portBOpt = r;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		repeat (100) @(negedge clk);
		chk(pinOe_n, 1'b0);
		chk(pinOut, 1'b0);
		chk(sysRst_n, 1'b0);
		wait_run(4200);
		chk(n + 100 >= POR_CYCLES, 1'b1);
		rchk(OFF_CONTROL, 8'h00);
		rchk(OFF_FIXED_CLEAR, portBOpt);
		rchk(16'h0123, 8'h00);
		wr(OFF_CONTROL, ctl(0, 0, 1, 2'b01));
		wr(OFF_CONTROL, 8'hff);
		rchk(OFF_CONTROL, ctl(0, 0, 1, 2'b01));
		// random spacing of the key pair, always inside the 64-cycle period
		for (i = 0; i < 12; i++)
		begin
			wr(OFF_SERVICE_KEY, KEY_ARM);
			rnd();
			repeat (r[3:0]) @(posedge clk);
			wr(OFF_SERVICE_KEY, KEY_FIRE);
			rnd();
			repeat (r[4:0]) @(posedge clk);
		end
		@(negedge clk);
		chk(sysRst_n, 1'b1);
		rchk(OFF_SERVICE_KEY, READ_NONE);
		wr(OFF_SERVICE_KEY, KEY_ARM);
		wr(OFF_SERVICE_KEY, KEY_FIRE);
		// a foreign value between the keys must not service
		wr(OFF_SERVICE_KEY, KEY_ARM);
		wr(OFF_SERVICE_KEY, 8'h12);
		wr(OFF_SERVICE_KEY, KEY_FIRE);
		n = 6;
		wait_rst(200);
		chk(n >= wdc(1) && n <= wdc(1) + 4, 1'b1);
		drive_len();
		chk(n, WD_DRIVE_CYC);
		wait_run(100);
		rchk(OFF_CONTROL, ctl(1, 0, 0, 0));
		rchk(OFF_CONTROL, 8'h00);
		// board holds the pin low well past the filter
		@(posedge clk);
		holdLow <= 1'b1;
		n = 0;
		wait_rst(20);
		chk(n <= 10, 1'b1);
		repeat (50) @(negedge clk);
		chk(sysRst_n, 1'b0);
		@(posedge clk);
		holdLow <= 1'b0;
		wait_run(20);
		rchk(OFF_CONTROL, 8'h00);
		wr(OFF_CONTROL, ctl(0, 1, 1, 2'b00));
		rchk(OFF_CONTROL, ctl(0, 1, 1, 2'b00));
		// stop entries faster than the 16-cycle period keep it alive
		for (i = 0; i < 12; i++)
		begin
			@(posedge clk);
			stopEntry <= 1'b1;
			@(posedge clk);
			stopEntry <= 1'b0;
			repeat (8) @(posedge clk);
		end
		@(negedge clk);
		chk(sysRst_n, 1'b1);
		@(posedge clk);
		stopEntry <= 1'b1;
		clkSlow <= 1'b1;
		@(posedge clk);
		stopEntry <= 1'b0;
		n = 0;
		wait_rst(12);
		chk(sysRst_n, 1'b0);
		clkSlow <= 1'b0;
		drive_len();
		chk(n, CM_DRIVE_CYC);
		wait_run(50);
		rchk(OFF_CONTROL, ctl(1, 0, 0, 0));
		// absent clock: the pin stays driven until the clock comes back
		wr(OFF_CONTROL, ctl(0, 1, 0, 2'b00));
		@(posedge clk);
		clkAbsent <= 1'b1;
		n = 0;
		wait_rst(12);
		chk(sysRst_n, 1'b0);
		repeat (20) @(posedge clk);
		clkAbsent <= 1'b0;
		@(negedge clk);
		chk(pinOe_n, 1'b0);
		drive_len();
		chk(n >= 4 && n <= 8, 1'b1);
		wait_run(50);
		rchk(OFF_CONTROL, ctl(1, 0, 0, 0));
		// second power-on, now in the mask-option configuration
		@(posedge clk);
		maskMode <= 1'b1;
		fixedOpt <= 1'b1;
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (100) @(negedge clk);
		chk(pinOe_n, 1'b1);
		wait_run(4200);
		rchk(OFF_FIXED_CLEAR, portBOpt);
		for (i = 0; i < 8; i++)
		begin
			rnd();
			wr(OFF_FIXED_CLEAR, {r[7:1], 1'b0});
			repeat (30) @(posedge clk);
		end
		@(negedge clk);
		chk(sysRst_n, 1'b1);
		wr(OFF_FIXED_CLEAR, 8'h00);
		wr(OFF_FIXED_CLEAR, 8'h01);
		n = 2;
		wait_rst(200);
		chk(n >= 63 && n <= 68, 1'b1);
		drive_len();
		chk(n, 8'h00);
		wait_run(100);
		give_verdict();
	end
endmodule // tb_rwu_reset_watchdog
